/* File: logic/cmcs_pkg.sv */
/*
 * Constants and types shared by the machine-cycle sequencer and its
 * internal data memory.
 * Assumes one oscillator clock, each oscillator period being one phase.
 */
package cmcs_pkg;

   // Machine-cycle states, Gray coded from first to sixth, not on the wrap back to first
   typedef enum logic [2:0] {
      CMCS_ST_FIRST = 3'h0,
      CMCS_ST_SECOND = 3'h1,
      CMCS_ST_THIRD = 3'h3,
      CMCS_ST_FOURTH = 3'h2,
      CMCS_ST_FIFTH = 3'h6,
      CMCS_ST_SIXTH = 3'h7
   } cmcs_state_t;

   localparam int unsigned CMCS_PHASES_PER_STATE = 2;
   localparam int unsigned CMCS_STATES_PER_CYCLE = 6;
   localparam int unsigned CMCS_OSC_PER_CYCLE =
      CMCS_PHASES_PER_STATE * CMCS_STATES_PER_CYCLE;
   localparam logic CMCS_PH1 = 1'b0;
   localparam logic CMCS_PH2 = 1'b1;

   // Instruction lengths and durations
   localparam logic [1:0] CMCS_LEN_ONE = 2'h1;
   localparam logic [1:0] CMCS_LEN_TWO = 2'h2;
   localparam logic [1:0] CMCS_LEN_THREE = 2'h3;
   localparam logic CMCS_CYC_FIRST = 1'b0;
   localparam logic CMCS_CYC_SECOND = 1'b1;

   // Opcodes handled by the execute stage
   localparam logic [7:0] CMCS_OP_NOP = 8'h00;
   localparam logic [7:0] CMCS_OP_SHORT_JUMP = 8'h80;
   localparam logic [7:0] CMCS_OP_EXT_MOVE_RD = 8'hE0;
   localparam logic [7:0] CMCS_OP_EXT_MOVE_WR = 8'hF0;
   localparam logic [7:0] CMCS_OP_DEC_BRANCH_DIR = 8'hD5;
   localparam logic [7:0] CMCS_OP_DEC_BRANCH_REG = 8'hD8;
   localparam logic [7:0] CMCS_OP_REG_MASK = 8'hF8;
   localparam logic [7:0] CMCS_OP_CMP_BRANCH_AI = 8'hB4;
   localparam logic [7:0] CMCS_OP_MOVE_DIR_IMM = 8'h75;
   localparam logic [7:0] CMCS_OP_MOVE_ACC_IMM = 8'h74;
   localparam logic [7:0] CMCS_OP_SET_BIT = 8'hD2;
   localparam logic [7:0] CMCS_OP_CLEAR_BIT = 8'hC2;
   localparam int unsigned CMCS_REG_SEL_W = 3;

   // Special-function space map
   localparam logic [7:0] CMCS_ADR_STACK_POINTER = 8'h81;
   localparam logic [7:0] CMCS_ADR_DATA_POINTER_LOW = 8'h82;
   localparam logic [7:0] CMCS_ADR_DATA_POINTER_HIGH = 8'h83;
   localparam logic [7:0] CMCS_ADR_STATUS_WORD = 8'hD0;
   localparam logic [7:0] CMCS_ADR_ACCUMULATOR = 8'hE0;
   localparam logic [7:0] CMCS_ADR_MUL_DIV_OPERAND = 8'hF0;
   localparam logic [7:0] CMCS_RST_STACK_POINTER = 8'h07;
   localparam logic [7:0] CMCS_RST_DATA_POINTER_LOW = 8'h00;
   localparam logic [7:0] CMCS_RST_DATA_POINTER_HIGH = 8'h00;
   localparam logic [7:0] CMCS_RST_STATUS_WORD = 8'h00;
   localparam logic [7:0] CMCS_RST_ACCUMULATOR = 8'h00;
   localparam logic [7:0] CMCS_RST_MUL_DIV_OPERAND = 8'h00;
   localparam logic [7:0] CMCS_UNMAPPED_READ = 8'h00;
   localparam logic [7:0] CMCS_BIT_ROW_LOW = 8'h80;
   localparam logic [7:0] CMCS_BIT_ROW_HIGH = 8'hF0;
   localparam logic [7:0] CMCS_BIT_AREA_BASE = 8'h20;
   localparam int unsigned CMCS_PSW_CY = 7;
   localparam int unsigned CMCS_PSW_RS1 = 4;
   localparam int unsigned CMCS_PSW_RS0 = 3;

   // Arithmetic steps and reset values
   localparam logic [15:0] CMCS_PC_STEP = 16'h0001;
   localparam logic [15:0] CMCS_RST_PC = 16'h0000;
   localparam logic [7:0] CMCS_BYTE_ONE = 8'h01;
   localparam logic [7:0] CMCS_BYTE_ZERO = 8'h00;

   // Internal data memory
   localparam int unsigned CMCS_RAM_DEPTH = 128;
   localparam int unsigned CMCS_RAM_AW = 7;

endpackage : cmcs_pkg

/* File: logic/cmcs_ram.sv */
/*
 * Internal data memory of the core, 128 bytes, registered read data.
 * Assumes the sequencer's clock and clock enable; no reset on contents.
 */
`timescale 1ns/1ps
`default_nettype none

module cmcs_ram
   import cmcs_pkg::*;
(
   input wire logic clk,
   input wire logic ce,
   input wire logic we,
   input wire logic [CMCS_RAM_AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);

   logic [7:0] mem_q [CMCS_RAM_DEPTH];

   // Read first port, old data on a colliding read
   always_ff @(posedge clk) begin
      if (ce) begin
         if (we) begin
            mem_q[addr] <= wdata;
         end
         rdata <= mem_q[addr];
      end
   end

endmodule : cmcs_ram

`default_nettype wire

/* File: logic/cmcs_core.sv */
/*
 * Machine-cycle sequencer of the 8-bit core: state/phase timing, code
 * fetches, external data moves, a small execute stage and the core-side
 * special-function registers.
 * Assumes the memory and logic module answers on the internal bus with
 * data registered one oscillator period after it sees address and strobe.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Six states, first to sixth, repeat in every machine cycle
// - Each state lasts two oscillator periods, twelve per cycle
// - Every state has a first and second phase half
// - Two code fetches issued every machine cycle except an external data move's second
// - Unneeded fetched byte discarded, program counter held
// - Opcode captured into instruction register in the first state
// - Second code fetch happens in the fourth state
// - Single-cycle instruction completes by end of the sixth state
// - External data move takes two cycles, no fetch in second
// - Fetches suppressed only in external data move second cycle
// - Decrement byte or register, branch when result nonzero
// - 16-bit address, 8-bit data, read/write/code/latch/reset strobes
// - Unoccupied special-function reads return zero
// - Unoccupied special-function writes change nothing
// - Row-base special-function registers 80h to F0h are bit addressable
// - Branch adds signed offset to next instruction address
// - Compare-branch sets carry when first operand is lower
module cmcs_core
   import cmcs_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic [7:0] DIN,
   output logic [15:0] ADDR,
   output logic [7:0] DOUT,
   output logic DOE,
   output logic RD_N,
   output logic WR_N,
   output logic CODE_READ_STROBE_N,
   output logic ALE,
   output logic RESET_N,
   output logic [2:0] MACHINE_STATE,
   output logic PHASE_TWO,
   output logic [7:0] OPCODE
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   cmcs_state_t state_q, state_d;
   logic ph_q, ph_d;
   logic cyc_q, cyc_d;
   logic [15:0] pc_q, pc_d;
   logic [7:0] op_q, b1_q, b2_q, mx_q;
   logic [7:0] acc_q, mdo_q, sp_q, dpl_q, dph_q;
   logic [7:1] psw_q;
   logic [7:0] psw_rd, sfs_rdata, ram_rdata, opnd, opnd_addr, bit_byte;
   logic [7:0] bit_mask, wr_data, rel;
   logic [15:0] rel_ext;
   logic [1:0] len;
   logic two_cyc, last_cyc, is_rd, is_wr, is_ext, is_dec_reg, bit_ok;
   logic movx2, movx2_d, fetch_slot, take_fetch, need, ex;
   logic wr_en, br_take, sfs_we, ram_we, next_cyc_movx2;
   logic fetch_d, ale_d, rd_d, wr_d;
   logic [15:0] addr_d;

   ////////////////////////////////////////////////////////////////////////
   // Decode of the held opcode
   always_comb begin
      is_rd = (op_q == CMCS_OP_EXT_MOVE_RD);
      is_wr = (op_q == CMCS_OP_EXT_MOVE_WR);
      is_ext = is_rd || is_wr;
      is_dec_reg = ((op_q & CMCS_OP_REG_MASK) == CMCS_OP_DEC_BRANCH_REG);
      len = CMCS_LEN_ONE;
      if (op_q == CMCS_OP_DEC_BRANCH_DIR || op_q == CMCS_OP_CMP_BRANCH_AI ||
          op_q == CMCS_OP_MOVE_DIR_IMM) begin
         len = CMCS_LEN_THREE;
      end else if (op_q == CMCS_OP_SHORT_JUMP || is_dec_reg ||
                   op_q == CMCS_OP_SET_BIT || op_q == CMCS_OP_CLEAR_BIT ||
                   op_q == CMCS_OP_MOVE_ACC_IMM) begin
         len = CMCS_LEN_TWO;
      end
      two_cyc = is_ext || (len == CMCS_LEN_THREE) ||
                op_q == CMCS_OP_SHORT_JUMP || is_dec_reg;
      last_cyc = two_cyc ? (cyc_q == CMCS_CYC_SECOND) : 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // State and phase sequencing
   always_comb begin
      ph_d = ~ph_q;
      state_d = state_q;
      cyc_d = cyc_q;
      if (ph_q == CMCS_PH2) begin
         unique case (state_q)
            CMCS_ST_FIRST: state_d = CMCS_ST_SECOND;
            CMCS_ST_SECOND: state_d = CMCS_ST_THIRD;
            CMCS_ST_THIRD: state_d = CMCS_ST_FOURTH;
            CMCS_ST_FOURTH: state_d = CMCS_ST_FIFTH;
            CMCS_ST_FIFTH: state_d = CMCS_ST_SIXTH;
            CMCS_ST_SIXTH: begin
               state_d = CMCS_ST_FIRST;
               cyc_d = last_cyc ? CMCS_CYC_FIRST : CMCS_CYC_SECOND;
            end
            default: state_d = CMCS_ST_FIRST;
         endcase
      end
   end

   // Reset parks at the last phase so the first fetch is a full state
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_q <= CMCS_ST_SIXTH;
         ph_q <= CMCS_PH2;
         cyc_q <= CMCS_CYC_FIRST;
      end else if (CE) begin
         state_q <= state_d;
         ph_q <= ph_d;
         cyc_q <= cyc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fetch capture and program counter
   always_comb begin
      movx2 = is_ext && (cyc_q == CMCS_CYC_SECOND);
      fetch_slot = (state_q == CMCS_ST_FIRST) || (state_q == CMCS_ST_FOURTH);
      take_fetch = CE && (ph_q == CMCS_PH2) && fetch_slot && !movx2;
      if (cyc_q == CMCS_CYC_FIRST && state_q == CMCS_ST_FIRST) begin
         need = 1'b1;
      end else begin
         need = ({cyc_q, state_q == CMCS_ST_FOURTH} < len);
      end
      ex = CE && (state_q == CMCS_ST_SIXTH) && (ph_q == CMCS_PH1) &&
           last_cyc;
      rel_ext = {{8{rel[7]}}, rel};
      pc_d = pc_q;
      if (take_fetch && need) begin
         pc_d = pc_q + CMCS_PC_STEP;
      end
      if (ex && br_take) begin
         pc_d = pc_q + rel_ext;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         pc_q <= CMCS_RST_PC;
      end else if (CE) begin
         pc_q <= pc_d;
      end
   end

   // Opcode in the first state, operands from later needed fetches
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         op_q <= CMCS_OP_NOP;
         b1_q <= CMCS_BYTE_ZERO;
         b2_q <= CMCS_BYTE_ZERO;
      end else if (take_fetch) begin
         if (cyc_q == CMCS_CYC_FIRST && state_q == CMCS_ST_FIRST) begin
            op_q <= DIN;
         end else if (need && cyc_q == CMCS_CYC_FIRST) begin
            b1_q <= DIN;
         end else if (need) begin
            b2_q <= DIN;
         end
      end
   end

   // Read data of an external data move, taken at end of fourth state
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         mx_q <= CMCS_BYTE_ZERO;
      end else if (CE && movx2 && is_rd && state_q == CMCS_ST_FOURTH &&
                   ph_q == CMCS_PH2) begin
         mx_q <= DIN;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operand addressing and execute
   always_comb begin
      if (b1_q[7]) begin
         bit_byte = {b1_q[7:3], 3'h0};
      end else begin
         bit_byte = CMCS_BIT_AREA_BASE + 8'(b1_q[6:3]);
      end
      bit_ok = !b1_q[7] || (bit_byte >= CMCS_BIT_ROW_LOW &&
                            bit_byte <= CMCS_BIT_ROW_HIGH);
      bit_mask = CMCS_BYTE_ONE << b1_q[2:0];
      if (is_dec_reg) begin
         opnd_addr = 8'({psw_q[CMCS_PSW_RS1:CMCS_PSW_RS0],
                         op_q[CMCS_REG_SEL_W-1:0]});
      end else if (op_q == CMCS_OP_SET_BIT || op_q == CMCS_OP_CLEAR_BIT) begin
         opnd_addr = bit_byte;
      end else begin
         opnd_addr = b1_q;
      end
      psw_rd = {psw_q, ^acc_q};
      unique case (opnd_addr)
         CMCS_ADR_STACK_POINTER: sfs_rdata = sp_q;
         CMCS_ADR_DATA_POINTER_LOW: sfs_rdata = dpl_q;
         CMCS_ADR_DATA_POINTER_HIGH: sfs_rdata = dph_q;
         CMCS_ADR_STATUS_WORD: sfs_rdata = psw_rd;
         CMCS_ADR_ACCUMULATOR: sfs_rdata = acc_q;
         CMCS_ADR_MUL_DIV_OPERAND: sfs_rdata = mdo_q;
         default: sfs_rdata = CMCS_UNMAPPED_READ;
      endcase
      opnd = opnd_addr[7] ? sfs_rdata : ram_rdata;
   end

   always_comb begin
      wr_en = 1'b0;
      wr_data = opnd;
      br_take = 1'b0;
      rel = b1_q;
      if (op_q == CMCS_OP_DEC_BRANCH_DIR || is_dec_reg) begin
         wr_en = 1'b1;
         wr_data = opnd - CMCS_BYTE_ONE;
         br_take = (wr_data != CMCS_BYTE_ZERO);
         rel = is_dec_reg ? b1_q : b2_q;
      end else if (op_q == CMCS_OP_CMP_BRANCH_AI) begin
         br_take = (acc_q != b1_q);
         rel = b2_q;
      end else if (op_q == CMCS_OP_SHORT_JUMP) begin
         br_take = 1'b1;
      end else if (op_q == CMCS_OP_MOVE_DIR_IMM) begin
         wr_en = 1'b1;
         wr_data = b2_q;
      end else if (op_q == CMCS_OP_SET_BIT) begin
         wr_en = bit_ok;
         wr_data = opnd | bit_mask;
      end else if (op_q == CMCS_OP_CLEAR_BIT) begin
         wr_en = bit_ok;
         wr_data = opnd & ~bit_mask;
      end
      sfs_we = ex && wr_en && opnd_addr[7];
      ram_we = ex && wr_en && !opnd_addr[7];
   end

   cmcs_ram u_ram (
      .clk(MCLK),
      .ce(CE),
      .we(ram_we),
      .addr(opnd_addr[CMCS_RAM_AW-1:0]),
      .wdata(wr_data),
      .rdata(ram_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Special-function registers; other addresses ignore writes
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         sp_q <= CMCS_RST_STACK_POINTER;
         dpl_q <= CMCS_RST_DATA_POINTER_LOW;
         dph_q <= CMCS_RST_DATA_POINTER_HIGH;
         mdo_q <= CMCS_RST_MUL_DIV_OPERAND;
      end else if (sfs_we) begin
         if (opnd_addr == CMCS_ADR_STACK_POINTER) begin
            sp_q <= wr_data;
         end
         if (opnd_addr == CMCS_ADR_DATA_POINTER_LOW) begin
            dpl_q <= wr_data;
         end
         if (opnd_addr == CMCS_ADR_DATA_POINTER_HIGH) begin
            dph_q <= wr_data;
         end
         if (opnd_addr == CMCS_ADR_MUL_DIV_OPERAND) begin
            mdo_q <= wr_data;
         end
      end
   end

   // Status word; parity bit is derived from the accumulator
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         psw_q <= CMCS_RST_STATUS_WORD[7:1];
      end else if (sfs_we && opnd_addr == CMCS_ADR_STATUS_WORD) begin
         psw_q <= wr_data[7:1];
      end else if (ex && op_q == CMCS_OP_CMP_BRANCH_AI) begin
         psw_q[CMCS_PSW_CY] <= (acc_q < b1_q);
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         acc_q <= CMCS_RST_ACCUMULATOR;
      end else if (sfs_we && opnd_addr == CMCS_ADR_ACCUMULATOR) begin
         acc_q <= wr_data;
      end else if (ex && op_q == CMCS_OP_MOVE_ACC_IMM) begin
         acc_q <= b1_q;
      end else if (ex && is_rd) begin
         acc_q <= mx_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Internal bus, registered from the coming slot
   always_comb begin
      movx2_d = is_ext && (cyc_d == CMCS_CYC_SECOND);
      next_cyc_movx2 = is_ext && (cyc_d == CMCS_CYC_FIRST);
      fetch_d = !movx2_d && (state_d == CMCS_ST_FIRST ||
                             state_d == CMCS_ST_FOURTH);
      ale_d = (ph_d == CMCS_PH2) &&
              ((state_d == CMCS_ST_SIXTH && !next_cyc_movx2) ||
               (state_d == CMCS_ST_THIRD && !movx2_d) ||
               (state_d == CMCS_ST_FIRST && movx2_d));
      rd_d = movx2_d && is_rd && (state_d == CMCS_ST_SECOND ||
             state_d == CMCS_ST_THIRD || state_d == CMCS_ST_FOURTH);
      wr_d = movx2_d && is_wr && (state_d == CMCS_ST_SECOND ||
             state_d == CMCS_ST_THIRD || state_d == CMCS_ST_FOURTH);
      addr_d = movx2_d ? {dph_q, dpl_q} : pc_d;
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ADDR <= CMCS_RST_PC;
         CODE_READ_STROBE_N <= 1'b1;
         ALE <= 1'b0;
      end else if (CE) begin
         ADDR <= addr_d;
         CODE_READ_STROBE_N <= !fetch_d;
         ALE <= ale_d;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         RD_N <= 1'b1;
         WR_N <= 1'b1;
         DOE <= 1'b0;
         DOUT <= CMCS_BYTE_ZERO;
      end else if (CE) begin
         RD_N <= !rd_d;
         WR_N <= !wr_d;
         DOE <= wr_d;
         DOUT <= wr_d ? acc_q : CMCS_BYTE_ZERO;
      end
   end

   // Module reset strobe released one edge after the core reset
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         RESET_N <= 1'b0;
      end else if (CE) begin
         RESET_N <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status outputs
   always_comb begin
      MACHINE_STATE = state_q;
      PHASE_TWO = ph_q;
      OPCODE = op_q;
   end

endmodule : cmcs_core

`default_nettype wire

/* File: verification/cmcs_core_props.sv */
/*
 * Port-level timing checker for cmcs_core.
 * Assumes binding to cmcs_core, one clock MCLK and async reset RST.
 */
`timescale 1ns/1ps
`default_nettype none

module cmcs_core_props
   import cmcs_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic [15:0] ADDR,
   input wire logic DOE,
   input wire logic RD_N,
   input wire logic WR_N,
   input wire logic CODE_READ_STROBE_N,
   input wire logic ALE,
   input wire logic RESET_N,
   input wire logic [2:0] MACHINE_STATE,
   input wire logic PHASE_TWO,
   input wire logic [7:0] OPCODE
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   function automatic logic [2:0] cmcs_succ(input logic [2:0] s);
      case (s)
         CMCS_ST_FIRST: return CMCS_ST_SECOND;
         CMCS_ST_SECOND: return CMCS_ST_THIRD;
         CMCS_ST_THIRD: return CMCS_ST_FOURTH;
         CMCS_ST_FOURTH: return CMCS_ST_FIFTH;
         CMCS_ST_FIFTH: return CMCS_ST_SIXTH;
         default: return CMCS_ST_FIRST;
      endcase
   endfunction : cmcs_succ

   ////////////////////////////////////////////////////////////////////////
   sequence s_first_fetch;
      $fell(CODE_READ_STROBE_N) && MACHINE_STATE == CMCS_ST_FIRST;
   endsequence
   sequence s_fourth_fetch;
      MACHINE_STATE == CMCS_ST_FOURTH && !CODE_READ_STROBE_N;
   endsequence
   sequence s_data_start;
      $fell(RD_N) || $fell(WR_N);
   endsequence

   ////////////////////////////////////////////////////////////////////////
   a_state_order: assert property (
      CE && PHASE_TWO |=> MACHINE_STATE == cmcs_succ($past(MACHINE_STATE)))
      else $error("state order broken");
   a_state_dwell: assert property (
      CE && !PHASE_TWO |=> $stable(MACHINE_STATE))
      else $error("state left after one period");
   a_phase_toggle: assert property (
      CE |=> PHASE_TWO != $past(PHASE_TWO))
      else $error("phase half did not alternate");
   a_two_fetches: assert property (
      s_first_fetch |-> ##[6:16] s_fourth_fetch)
      else $error("second fetch missing");
   a_fetch_slot: assert property (
      !CODE_READ_STROBE_N |->
         MACHINE_STATE == CMCS_ST_FIRST || MACHINE_STATE == CMCS_ST_FOURTH)
      else $error("fetch outside first or fourth state");
   a_opcode_load: assert property (
      $changed(OPCODE) |->
         $past(MACHINE_STATE) == CMCS_ST_FIRST && $past(PHASE_TWO))
      else $error("opcode loaded outside first state");
   a_ext_no_fetch: assert property (
      !RD_N || !WR_N |-> CODE_READ_STROBE_N)
      else $error("fetch during data move");
   a_fetch_kept: assert property (
      MACHINE_STATE == CMCS_ST_FOURTH && RD_N && WR_N |->
         !CODE_READ_STROBE_N)
      else $error("fetch skipped outside data move");
   a_data_addr: assert property (
      s_data_start |-> $past(ALE) && $stable(ADDR) && (WR_N || DOE))
      else $error("data strobe without latched address");
   a_reset_idle: assert property (disable iff (1'b0)
      RST |-> !RESET_N && CODE_READ_STROBE_N && RD_N && WR_N && !ALE)
      else $error("bus not idle in reset");
endmodule : cmcs_core_props

bind cmcs_core cmcs_core_props u_props (.MCLK(MCLK), .RST(RST), .CE(CE),
   .ADDR(ADDR), .DOE(DOE), .RD_N(RD_N), .WR_N(WR_N),
   .CODE_READ_STROBE_N(CODE_READ_STROBE_N), .ALE(ALE), .RESET_N(RESET_N),
   .MACHINE_STATE(MACHINE_STATE), .PHASE_TWO(PHASE_TWO), .OPCODE(OPCODE));

`default_nettype wire

/* File: verification/cmcs_mem_model.sv */
/*
 * Model of the memory and logic module on the internal bus.
 * Assumes registered reads one MCLK after address and strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module cmcs_mem_model
(
   input wire logic MCLK,
   input wire logic [15:0] ADDR,
   input wire logic [7:0] DOUT,
   input wire logic DOE,
   input wire logic RD_N,
   input wire logic WR_N,
   input wire logic CODE_READ_STROBE_N,
   input wire logic RESET_N,
   output logic [7:0] DIN
);
   logic [7:0] code_mem [0:255];
   logic [7:0] data_mem [0:65535];
   int fetch_cnt [0:255];
   int n_writes;
   logic code_n_q;
   logic wr_n_q;

   initial begin
      DIN = 8'h5A;
      n_writes = 0;
      code_n_q = 1'b1;
      wr_n_q = 1'b1;
      for (int i = 0; i < 256; i++) begin
         code_mem[i] = 8'h00;
         fetch_cnt[i] = 0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Undriven bus toggles so stale data never looks valid
   always @(posedge MCLK) begin
      code_n_q <= CODE_READ_STROBE_N;
      wr_n_q <= WR_N;
      if (!RESET_N) begin
         DIN <= ~DIN;
      end else if (!CODE_READ_STROBE_N) begin
         DIN <= code_mem[ADDR[7:0]];
         if (code_n_q) begin
            fetch_cnt[ADDR[7:0]] <= fetch_cnt[ADDR[7:0]] + 1;
         end
      end else if (!RD_N) begin
         DIN <= data_mem[ADDR];
      end else begin
         DIN <= ~DIN;
      end
      if (RESET_N && !WR_N && DOE) begin
         data_mem[ADDR] <= DOUT;
         if (wr_n_q) begin
            n_writes <= n_writes + 1;
         end
      end
   end
endmodule : cmcs_mem_model

`default_nettype wire

/* File: verification/cmcs_core_bench.sv */
/*
 * Self-checking bench: runs a short program through cmcs_core.
 * Assumes the memory model and the bound timing checker.
 */
`timescale 1ns/1ps
`default_nettype none

module cmcs_core_bench;
   logic MCLK;
   logic RST;
   logic CE;
   logic [7:0] DIN;
   logic [7:0] DOUT;
   logic [7:0] OPCODE;
   logic [15:0] ADDR;
   logic DOE, RD_N, WR_N, CODE_READ_STROBE_N, ALE, RESET_N, PHASE_TWO;
   logic [2:0] MACHINE_STATE;
   logic [7:0] held;
   int failures;
   int n_compared;
   // Moves, count loop, jumps, spare write, bit set, compares, idle loop
   localparam logic [527:0] PROG = {104'h7455_758312_758234_F0_758235_E0,
      160'h758236_F0_750003_D8FE_8002_7411_758237_758400_F0,
      136'hD2E0_B4AB02_758238_F0_B4FF02_7411_D5D002,
      128'h7411_B40002_7411_D5D002_758239_F0_80FE};

   cmcs_core uut (.MCLK(MCLK), .RST(RST), .CE(CE), .DIN(DIN), .ADDR(ADDR),
      .DOUT(DOUT), .DOE(DOE), .RD_N(RD_N), .WR_N(WR_N),
      .CODE_READ_STROBE_N(CODE_READ_STROBE_N), .ALE(ALE),
      .RESET_N(RESET_N), .MACHINE_STATE(MACHINE_STATE),
      .PHASE_TWO(PHASE_TWO), .OPCODE(OPCODE));
   cmcs_mem_model u_mem (.MCLK(MCLK), .ADDR(ADDR), .DOUT(DOUT), .DOE(DOE),
      .RD_N(RD_N), .WR_N(WR_N), .CODE_READ_STROBE_N(CODE_READ_STROBE_N),
      .RESET_N(RESET_N), .DIN(DIN));

   ////////////////////////////////////////////////////////////////////////
   task automatic check8(input logic [7:0] got, input logic [7:0] exp,
      input string what);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask : check8

   task automatic check_int(input int got, input int exp, input string what);
      n_compared++;
      if (got != exp) begin
         failures++;
         $display("ERROR %0t %s: got %0d exp %0d", $time, what, got, exp);
      end
   endtask : check_int

   task automatic tick(input int n);
      repeat (n) @(posedge MCLK);
      #2;
   endtask : tick

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////////////////////////////////////
   initial begin
      MCLK = 1'b0;
      forever #25 MCLK = ~MCLK;
   end

   initial begin
      #(50 * 10000);
      failures++;
      $display("ERROR %0t watchdog expired", $time);
      print_verdict();
   end

   initial begin
      int k;
      RST = 1'b0;
      CE = 1'b1;
      failures = 0;
      n_compared = 0;
      #1;
      RST = 1'b1;
      for (int i = 0; i < 66; i++) begin
         u_mem.code_mem[i] = PROG[527 - 8 * i -: 8];
      end
      u_mem.data_mem[16'h1235] = 8'hAA;
      tick(20);
      check8({RESET_N, CODE_READ_STROBE_N, RD_N, WR_N, ALE, MACHINE_STATE},
         8'h77, "reset outputs");
      check8(OPCODE, 8'h00, "reset opcode");
      $display("test reset done");
      RST = 1'b0;
      tick(3);
      check8({4'h0, PHASE_TWO, MACHINE_STATE}, 8'h01, "second state");
      held = {4'h0, PHASE_TWO, MACHINE_STATE};
      CE = 1'b0;
      tick(4);
      check8({4'h0, PHASE_TWO, MACHINE_STATE}, held, "frozen state");
      CE = 1'b1;
      $display("test freeze done");
      for (k = 0; k < 3000 && u_mem.n_writes < 5; k++) begin
         tick(1);
      end
      tick(60);
      check_int(u_mem.n_writes, 5, "data writes");
      check8(u_mem.data_mem[16'h1234], 8'h55, "written byte");
      check8(u_mem.data_mem[16'h1236], 8'hAA, "read then written");
      check8(u_mem.data_mem[16'h1237], 8'hAA, "after jump");
      check8(u_mem.data_mem[16'h1238], 8'hAB, "bit set");
      check8(u_mem.data_mem[16'h1239], 8'hAB, "carry branches");
      check8(u_mem.data_mem[16'h1200], 8'hXX, "no stray write");
      // One dropped fetch before the move, then one per byte
      check_int(u_mem.fetch_cnt[8'h09], 2, "repeat fetch");
      check_int(u_mem.fetch_cnt[8'h0C], 2, "repeat fetch");
      // One dropped fetch, then three loop passes
      check_int(u_mem.fetch_cnt[8'h14], 4, "loop passes");
      check_int(u_mem.fetch_cnt[8'h19], 0, "skipped bytes");
      check8(OPCODE, 8'h80, "idle loop opcode");
      $display("test program done");
      print_verdict();
   end
endmodule : cmcs_core_bench

`default_nettype wire
